// ---- logic/dpc_capture_unit.sv ----
// Two-channel position capture unit with parameter read port.
// Assumes trigger inputs asynchronous to clk and position redefinitions given as a delta.
`timescale 1ns/1ns
module dpc_capture_unit
    import dpc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Trigger inputs and channel activation
    input  wire logic              trigger_input_one,
    input  wire logic              trigger_input_two,
    input  wire logic              capture_enable_one,
    input  wire logic              capture_enable_two,
    // Position source
    input  wire logic [POS_W-1:0]  actual_position,
    input  wire logic              pos_redefine,
    input  wire logic [POS_W-1:0]  pos_delta,
    // Parameter read port
    input  wire logic              rd_en,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    output logic                   rd_valid,
    output logic                   rd_err
);

    logic [DPC_CH-1:0] trig_in;
    logic [DPC_CH-1:0] en_in;
    logic [DPC_CH-1:0] sync1;
    logic [DPC_CH-1:0] sync2;
    logic [DPC_CH-1:0] sync3;
    logic [DPC_CH-1:0] en_q;
    logic [DPC_CH-1:0] next_sync1;
    logic [DPC_CH-1:0] next_sync2;
    logic [DPC_CH-1:0] next_sync3;
    logic [DPC_CH-1:0] next_en_q;
    logic [DPC_CH-1:0] rise_raw;
    logic [DPC_CH-1:0] fall_raw;
    logic [DPC_CH-1:0] rise_evt;
    logic [DPC_CH-1:0] fall_evt;
    logic [DPC_CH-1:0] arm;
    logic [DPC_CH-1:0] cons_read;
    logic [DPC_CH-1:0] captured;
    logic [POS_W-1:0]  cap_pos   [DPC_CH];
    logic [POS_W-1:0]  rise_pos  [DPC_CH];
    logic [POS_W-1:0]  fall_pos  [DPC_CH];
    logic [POS_W-1:0]  cons_pos  [DPC_CH];
    logic [CNT_W-1:0]  total_cnt [DPC_CH];
    logic [CNT_W-1:0]  rise_cnt  [DPC_CH];
    logic [CNT_W-1:0]  fall_cnt  [DPC_CH];
    logic [CNT_W-1:0]  summary;
    logic [CNT_W-1:0]  status;
    dpc_sel_t          sel;
    logic              sel_ch;
    logic [DATA_W-1:0] next_rd_data;
    logic              next_rd_valid;
    logic              next_rd_err;

    assign trig_in = {trigger_input_two, trigger_input_one};
    assign en_in   = {capture_enable_two, capture_enable_one};

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic dpc_sel_t dpc_decode(input logic [ADDR_W-1:0] a);
        unique case (a)
            OFS_STATUS:                           return SEL_STATUS;
            OFS_SUMMARY:                          return SEL_SUMMARY;
            OFS_CH1_POS, OFS_CH2_POS:             return SEL_POS;
            OFS_CH1_TOTAL, OFS_CH2_TOTAL:         return SEL_TOTAL;
            OFS_CH1_TOTAL_CON, OFS_CH2_TOTAL_CON: return SEL_TOTAL_CON;
            OFS_CH1_POS_CON, OFS_CH2_POS_CON:     return SEL_POS_CON;
            OFS_CH1_RISE_POS, OFS_CH2_RISE_POS:   return SEL_RISE_POS;
            OFS_CH1_FALL_POS, OFS_CH2_FALL_POS:   return SEL_FALL_POS;
            OFS_CH1_RISE_CNT, OFS_CH2_RISE_CNT:   return SEL_RISE_CNT;
            OFS_CH1_FALL_CNT, OFS_CH2_FALL_CNT:   return SEL_FALL_CNT;
            default:                              return SEL_NONE;
        endcase
    endfunction : dpc_decode

    // Channel two addresses are the ones listed second in each pair.
    function automatic logic dpc_chan(input logic [ADDR_W-1:0] a);
        return (a == OFS_CH2_POS) || (a == OFS_CH2_TOTAL) || (a == OFS_CH2_TOTAL_CON)
            || (a == OFS_CH2_POS_CON) || (a == OFS_CH2_RISE_POS)
            || (a == OFS_CH2_FALL_POS) || (a == OFS_CH2_RISE_CNT)
            || (a == OFS_CH2_FALL_CNT);
    endfunction : dpc_chan

    function automatic logic [DATA_W-1:0] zx(input logic [CNT_W-1:0] v);
        return {{(DATA_W-CNT_W){1'b0}}, v};
    endfunction : zx

    assign sel    = dpc_decode(rd_addr);
    assign sel_ch = dpc_chan(rd_addr);

    // ------------------------------------------------------------
    // Synchronisers, edge and activation detect
    // ------------------------------------------------------------
    // Only sync2 and sync3 feed the edge logic, so sync1 may go metastable.
    always_comb begin
        next_sync1 = trig_in;
        next_sync2 = sync1;
        next_sync3 = sync2;
        next_en_q  = en_in;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            en_q  <= '0;
        end else if (ce) begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            en_q  <= next_en_q;
        end
    end

    assign rise_raw  = sync2 & ~sync3;
    assign fall_raw  = ~sync2 & sync3;
    assign rise_evt  = rise_raw & en_in;
    assign fall_evt  = fall_raw & en_in;
    assign arm       = en_in & ~en_q;

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DPC_CH; g++) begin : g_ch
            assign cons_read[g] = rd_en && (sel == SEL_TOTAL_CON)
                                  && (sel_ch == 1'(g));
            assign summary[g*SUM_STRIDE +: NIB_W]
                = rise_cnt[g][NIB_W-1:0];
            assign summary[g*SUM_STRIDE+SUM_FALL +: NIB_W]
                = fall_cnt[g][NIB_W-1:0];
            dpc_channel u_ch (
                .clk             (clk),
                .rst_n           (rst_n),
                .ce              (ce),
                .arm             (arm[g]),
                .rise_evt        (rise_evt[g]),
                .fall_evt        (fall_evt[g]),
                .cons_read       (cons_read[g]),
                .actual_position (actual_position),
                .pos_redefine    (pos_redefine),
                .pos_delta       (pos_delta),
                .cap_pos         (cap_pos[g]),
                .rise_pos        (rise_pos[g]),
                .fall_pos        (fall_pos[g]),
                .cons_pos        (cons_pos[g]),
                .total_cnt       (total_cnt[g]),
                .rise_cnt        (rise_cnt[g]),
                .fall_cnt        (fall_cnt[g]),
                .captured        (captured[g])
            );
        end
    endgenerate

    assign status = {{(CNT_W-DPC_CH){1'b0}}, captured};

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_comb begin
        next_rd_data  = DATA_RST;
        next_rd_valid = rd_en;
        next_rd_err   = rd_en && (sel == SEL_NONE);
        if (rd_en) begin
            unique case (sel)
                SEL_STATUS:    next_rd_data = zx(status);
                SEL_SUMMARY:   next_rd_data = zx(summary);
                SEL_POS:       next_rd_data = cap_pos[sel_ch];
                SEL_TOTAL:     next_rd_data = zx(total_cnt[sel_ch]);
                SEL_TOTAL_CON: next_rd_data = zx(total_cnt[sel_ch]);
                SEL_POS_CON:   next_rd_data = cons_pos[sel_ch];
                SEL_RISE_POS:  next_rd_data = rise_pos[sel_ch];
                SEL_FALL_POS:  next_rd_data = fall_pos[sel_ch];
                SEL_RISE_CNT:  next_rd_data = zx(rise_cnt[sel_ch]);
                SEL_FALL_CNT:  next_rd_data = zx(fall_cnt[sel_ch]);
                SEL_NONE:      next_rd_data = DATA_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data  <= DATA_RST;
            rd_valid <= 1'b0;
            rd_err   <= 1'b0;
        end else if (ce) begin
            rd_data  <= next_rd_data;
            rd_valid <= next_rd_valid;
            rd_err   <= next_rd_err;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    generate
        for (g = 0; g < DPC_CH; g++) begin : g_chk
            sequence s_pin_rise;
                (!trig_in[g] && ce) [*2] ##1 (trig_in[g] && ce) [*2];
            endsequence
            sequence s_clean_rise;
                ce && rise_evt[g] && !arm[g];
            endsequence
            sequence s_clean_fall;
                ce && fall_evt[g] && !arm[g];
            endsequence

            property p_sync_rise;
                @(posedge clk) disable iff (!rst_n)
                s_pin_rise |=> rise_raw[g];
            endproperty
            a_sync_rise: assert property (p_sync_rise)
                else $error("input rise not seen after two sync stages");

            property p_rise_cnt;
                @(posedge clk) disable iff (!rst_n)
                s_clean_rise |=> rise_cnt[g] == $past(rise_cnt[g]) + 16'h0001;
            endproperty
            a_rise_cnt: assert property (p_rise_cnt)
                else $error("rising counter did not advance by one");

            property p_fall_cnt;
                @(posedge clk) disable iff (!rst_n)
                s_clean_fall |=> fall_cnt[g] == $past(fall_cnt[g]) + 16'h0001;
            endproperty
            a_fall_cnt: assert property (p_fall_cnt)
                else $error("falling counter did not advance by one");

            property p_total_cnt;
                @(posedge clk) disable iff (!rst_n)
                (ce && (rise_evt[g] || fall_evt[g]) && !arm[g])
                |=> total_cnt[g] == $past(total_cnt[g]) + 16'h0001;
            endproperty
            a_total_cnt: assert property (p_total_cnt)
                else $error("total counter did not advance by one");

            property p_arm_clear;
                @(posedge clk) disable iff (!rst_n)
                (ce && arm[g] && !rise_evt[g] && !fall_evt[g])
                |=> (total_cnt[g] == CNT_RST) && (rise_cnt[g] == CNT_RST)
                    && (fall_cnt[g] == CNT_RST) && !captured[g];
            endproperty
            a_arm_clear: assert property (p_arm_clear)
                else $error("activation left counters nonzero");

            property p_cons;
                @(posedge clk) disable iff (!rst_n)
                (ce && cons_read[g] && !pos_redefine)
                |=> cons_pos[g] == $past(cap_pos[g]);
            endproperty
            a_cons: assert property (p_cons)
                else $error("coherent position not frozen on read");

            property p_cons_hold;
                @(posedge clk) disable iff (!rst_n)
                (ce && !cons_read[g] && !pos_redefine) |=> $stable(cons_pos[g]);
            endproperty
            a_cons_hold: assert property (p_cons_hold)
                else $error("coherent position moved without a read");

            property p_cap_pos;
                @(posedge clk) disable iff (!rst_n)
                (ce && (rise_evt[g] || fall_evt[g]))
                |=> cap_pos[g] == $past(actual_position) && captured[g];
            endproperty
            a_cap_pos: assert property (p_cap_pos)
                else $error("captured position or status flag wrong");

            property p_redefine;
                @(posedge clk) disable iff (!rst_n)
                (ce && pos_redefine && !rise_evt[g])
                |=> rise_pos[g] == $past(rise_pos[g]) + $past(pos_delta);
            endproperty
            a_redefine: assert property (p_redefine)
                else $error("stored position not shifted by delta");

            property p_fall_pos;
                @(posedge clk) disable iff (!rst_n)
                s_clean_fall |=> fall_pos[g] == $past(actual_position)
                    && rise_pos[g] == $past(rise_pos[g]) + ($past(pos_redefine)
                       ? $past(pos_delta) : POS_RST);
            endproperty
            a_fall_pos: assert property (p_fall_pos)
                else $error("falling-edge position wrong");

            property p_rise_pos;
                @(posedge clk) disable iff (!rst_n)
                s_clean_rise |=> rise_pos[g] == $past(actual_position);
            endproperty
            a_rise_pos: assert property (p_rise_pos)
                else $error("rising-edge position wrong");
        end
    endgenerate

    property p_summary;
        @(posedge clk) disable iff (!rst_n)
        (ce && rd_en && sel == SEL_SUMMARY)
        |=> rd_valid && rd_data == zx({$past(fall_cnt[1][NIB_W-1:0]),
                                       $past(rise_cnt[1][NIB_W-1:0]),
                                       $past(fall_cnt[0][NIB_W-1:0]),
                                       $past(rise_cnt[0][NIB_W-1:0])});
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary word does not match counter nibbles");

endmodule : dpc_capture_unit

// ---- inc/dpc_pkg.sv ----
// Constants, register offsets and read-select codes of the dual position capture unit.
// Assumes a single 25 MHz clock and parameter reads at the printed register addresses.
package dpc_pkg;

    // ------------------------------------------------------------
    // Widths and channel count
    // ------------------------------------------------------------
    localparam int DPC_CH     = 2;
    localparam int POS_W      = 32;
    localparam int CNT_W      = 16;
    localparam int DATA_W     = 32;
    localparam int ADDR_W     = 16;
    localparam int NIB_W      = 4;
    localparam int SUM_STRIDE = 8;
    localparam int SUM_FALL   = 4;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS        = 16'h0a02;
    localparam logic [ADDR_W-1:0] OFS_CH1_POS       = 16'h0a0c;
    localparam logic [ADDR_W-1:0] OFS_CH2_POS       = 16'h0a0e;
    localparam logic [ADDR_W-1:0] OFS_CH1_TOTAL     = 16'h0a10;
    localparam logic [ADDR_W-1:0] OFS_CH2_TOTAL     = 16'h0a12;
    localparam logic [ADDR_W-1:0] OFS_CH1_TOTAL_CON = 16'h0a2e;
    localparam logic [ADDR_W-1:0] OFS_CH1_POS_CON   = 16'h0a30;
    localparam logic [ADDR_W-1:0] OFS_CH2_TOTAL_CON = 16'h0a32;
    localparam logic [ADDR_W-1:0] OFS_CH2_POS_CON   = 16'h0a34;
    localparam logic [ADDR_W-1:0] OFS_CH1_RISE_POS  = 16'h0a4a;
    localparam logic [ADDR_W-1:0] OFS_CH1_FALL_POS  = 16'h0a4c;
    localparam logic [ADDR_W-1:0] OFS_CH2_RISE_POS  = 16'h0a4e;
    localparam logic [ADDR_W-1:0] OFS_CH2_FALL_POS  = 16'h0a50;
    localparam logic [ADDR_W-1:0] OFS_CH1_RISE_CNT  = 16'h0a56;
    localparam logic [ADDR_W-1:0] OFS_CH1_FALL_CNT  = 16'h0a58;
    localparam logic [ADDR_W-1:0] OFS_CH2_RISE_CNT  = 16'h0a5a;
    localparam logic [ADDR_W-1:0] OFS_CH2_FALL_CNT  = 16'h0a5c;
    localparam logic [ADDR_W-1:0] OFS_SUMMARY       = 16'h0a5e;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
    localparam logic [POS_W-1:0]  POS_RST  = 32'h0000_0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Read selects
    // ------------------------------------------------------------
    typedef enum {
        SEL_NONE, SEL_STATUS, SEL_SUMMARY,
        SEL_POS, SEL_TOTAL, SEL_TOTAL_CON, SEL_POS_CON,
        SEL_RISE_POS, SEL_FALL_POS, SEL_RISE_CNT, SEL_FALL_CNT
    } dpc_sel_t;

endpackage : dpc_pkg

// ---- logic/dpc_channel.sv ----
// One capture channel: edge counters, captured positions and the coherent pair.
// Assumes edge pulses already synchronised and gated by the channel enable.
`timescale 1ns/1ns
module dpc_channel
    import dpc_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // Channel events
    input  wire logic             arm,
    input  wire logic             rise_evt,
    input  wire logic             fall_evt,
    input  wire logic             cons_read,
    // Position source
    input  wire logic [POS_W-1:0] actual_position,
    input  wire logic             pos_redefine,
    input  wire logic [POS_W-1:0] pos_delta,
    // Channel state
    output logic      [POS_W-1:0] cap_pos,
    output logic      [POS_W-1:0] rise_pos,
    output logic      [POS_W-1:0] fall_pos,
    output logic      [POS_W-1:0] cons_pos,
    output logic      [CNT_W-1:0] total_cnt,
    output logic      [CNT_W-1:0] rise_cnt,
    output logic      [CNT_W-1:0] fall_cnt,
    output logic                  captured
);

    logic [POS_W-1:0] next_cap_pos;
    logic [POS_W-1:0] next_rise_pos;
    logic [POS_W-1:0] next_fall_pos;
    logic [POS_W-1:0] next_cons_pos;
    logic [CNT_W-1:0] next_total_cnt;
    logic [CNT_W-1:0] next_rise_cnt;
    logic [CNT_W-1:0] next_fall_cnt;
    logic             next_captured;
    logic             evt;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        evt            = rise_evt | fall_evt;
        next_cap_pos   = cap_pos;
        next_rise_pos  = rise_pos;
        next_fall_pos  = fall_pos;
        next_cons_pos  = cons_pos;
        next_total_cnt = arm ? CNT_RST : total_cnt;
        next_rise_cnt  = arm ? CNT_RST : rise_cnt;
        next_fall_cnt  = arm ? CNT_RST : fall_cnt;
        next_captured  = captured & ~arm;
        // A new origin shifts every stored position by the same delta.
        if (pos_redefine) begin
            next_cap_pos  = cap_pos + pos_delta;
            next_rise_pos = rise_pos + pos_delta;
            next_fall_pos = fall_pos + pos_delta;
            next_cons_pos = cons_pos + pos_delta;
        end
        // The frozen copy takes the position as it stands before this edge.
        if (cons_read) begin
            next_cons_pos = pos_redefine ? next_cap_pos : cap_pos;
        end
        if (evt) begin
            next_cap_pos   = actual_position;
            next_total_cnt = next_total_cnt + 1'b1;
            next_captured  = 1'b1;
        end
        if (rise_evt) begin
            next_rise_pos = actual_position;
            next_rise_cnt = next_rise_cnt + 1'b1;
        end
        if (fall_evt) begin
            next_fall_pos = actual_position;
            next_fall_cnt = next_fall_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_pos   <= POS_RST;
            rise_pos  <= POS_RST;
            fall_pos  <= POS_RST;
            cons_pos  <= POS_RST;
            total_cnt <= CNT_RST;
            rise_cnt  <= CNT_RST;
            fall_cnt  <= CNT_RST;
            captured  <= 1'b0;
        end else if (ce) begin
            cap_pos   <= next_cap_pos;
            rise_pos  <= next_rise_pos;
            fall_pos  <= next_fall_pos;
            cons_pos  <= next_cons_pos;
            total_cnt <= next_total_cnt;
            rise_cnt  <= next_rise_cnt;
            fall_cnt  <= next_fall_cnt;
            captured  <= next_captured;
        end
    end

endmodule : dpc_channel

// ---- verification/dpc_trig_model.sv ----
// Model of the external trigger source driving both capture pins.
// Assumes the bench spaces toggle requests at least four clocks apart per pin.
`timescale 1ns/1ns
module dpc_trig_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Toggle requests and pins
    input  wire logic [1:0] flip,
    output logic      [1:0] pin
);
    // Each level is held for several clocks so the synchroniser sees it.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pin <= 2'h0;
        else pin <= pin ^ flip;
    end
endmodule : dpc_trig_model

// ---- verification/dpc_capture_unit_tb.sv ----
// Self-checking bench for the dual position capture unit.
// Assumes the trigger model on the pins and reads through the parameter port.
`timescale 1ns/1ns
module dpc_capture_unit_tb
    import dpc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, rd_en = 1'b0, pos_redefine = 1'b0;
    logic        rd_valid, rd_err;
    logic [1:0]  flip = 2'h0, pin, en = 2'h0, lvl = 2'h0, st = 2'h0;
    logic [31:0] actual_position = 32'h0, pos_delta = 32'h0, rd_data, s = 32'h5b;
    logic [15:0] rd_addr = 16'h0;
    logic [31:0] rp[2], fp[2], cp[2], kp[2];
    logic [15:0] rc[2], fc[2], tc[2];
    logic [32:0] q[$], e;
    int          n_errors = 0, cmp_count = 0;

    always #20 clk = ~clk;

    dpc_trig_model trig (.clk(clk), .rst_n(rst_n), .flip(flip), .pin(pin));
    dpc_capture_unit uut (.clk(clk), .rst_n(rst_n), .ce(ce),
        .trigger_input_one(pin[0]), .trigger_input_two(pin[1]),
        .capture_enable_one(en[0]), .capture_enable_two(en[1]),
        .actual_position(actual_position), .pos_redefine(pos_redefine),
        .pos_delta(pos_delta), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_err(rd_err));

    // Every answer is matched against the oldest expected value, mid-cycle where it has settled.
    always @(negedge clk) if (rd_valid === 1'b1) begin
        e = (q.size() > 0) ? q.pop_front() : '1;
        cmp_count++;
        if ({rd_err, rd_data} !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, {rd_err, rd_data}, e);
        end
    end

    function automatic logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic rd(input logic [15:0] a, input logic [32:0] x);
        @(posedge clk);
        rd_en <= 1'b1;
        rd_addr <= a;
        q.push_back(x);
        @(posedge clk);
        rd_en <= 1'b0;
    endtask : rd

    // Toggle one pin at a fresh position and update the expected state.
    task automatic pulse_pin(input int c);
        @(posedge clk);
        flip[c] <= 1'b1;
        actual_position <= xs();
        @(posedge clk);
        flip <= 2'h0;
        repeat (4) @(posedge clk);
        lvl[c] = ~lvl[c];
        if (en[c]) begin
            if (lvl[c]) begin rc[c]++; rp[c] = actual_position; end
            else begin fc[c]++; fp[c] = actual_position; end
            tc[c]++;
            cp[c] = actual_position;
            st[c] = 1'b1;
        end
    endtask : pulse_pin

    task automatic redef();
        @(posedge clk);
        pos_delta <= xs();
        pos_redefine <= 1'b1;
        @(posedge clk);
        pos_redefine <= 1'b0;
        foreach (rp[i]) begin
            rp[i] += pos_delta; fp[i] += pos_delta; cp[i] += pos_delta; kp[i] += pos_delta;
        end
    endtask : redef

    task automatic chk(input int c);
        rd(c ? OFS_CH2_POS : OFS_CH1_POS, {1'b0, cp[c]});
        rd(c ? OFS_CH2_RISE_POS : OFS_CH1_RISE_POS, {1'b0, rp[c]});
        rd(c ? OFS_CH2_FALL_POS : OFS_CH1_FALL_POS, {1'b0, fp[c]});
        rd(c ? OFS_CH2_TOTAL : OFS_CH1_TOTAL, {17'h0, tc[c]});
        rd(c ? OFS_CH2_RISE_CNT : OFS_CH1_RISE_CNT, {17'h0, rc[c]});
        rd(c ? OFS_CH2_FALL_CNT : OFS_CH1_FALL_CNT, {17'h0, fc[c]});
        rd(OFS_STATUS, {31'h0, st});
        rd(OFS_SUMMARY, {17'h0, fc[1][3:0], rc[1][3:0], fc[0][3:0], rc[0][3:0]});
    endtask : chk

    task automatic give_verdict();
        $display("comparisons %0d, errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict

    initial begin
        foreach (rp[i]) begin
            rp[i] = 0; fp[i] = 0; cp[i] = 0; kp[i] = 0; rc[i] = 0; fc[i] = 0; tc[i] = 0;
        end
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_STATUS, 33'h0);
        rd(16'h0a00, 33'h1_0000_0000);
        en <= 2'h3;
        repeat (3) @(posedge clk);
        // Enough edges that every summary nibble wraps past fifteen.
        for (int k = 0; k < 68; k++) begin
            pulse_pin(k % 2);
            if (k % 16 >= 14) chk(k % 2);
        end
        redef();
        chk(0);
        chk(1);
        rd(OFS_CH2_TOTAL_CON, {17'h0, tc[1]});
        kp[1] = cp[1];
        pulse_pin(1);
        rd(OFS_CH2_POS_CON, {1'b0, kp[1]});
        redef();
        rd(OFS_CH2_POS_CON, {1'b0, kp[1]});
        rd(OFS_CH1_POS_CON, {1'b0, kp[0]});
        rd(OFS_CH1_TOTAL_CON, {17'h0, tc[0]});
        kp[0] = cp[0];
        rd(OFS_CH1_POS_CON, {1'b0, kp[0]});
        chk(1);
        // A disabled channel ignores edges; re-enabling clears its counters.
        en[0] <= 1'b0;
        pulse_pin(0);
        chk(0);
        en[0] <= 1'b1;
        repeat (2) @(posedge clk);
        rc[0] = 0; fc[0] = 0; tc[0] = 0; st[0] = 1'b0;
        chk(0);
        pulse_pin(0);
        chk(0);
        // With the clock enable low a pending read must never be answered.
        @(posedge clk);
        ce <= 1'b0;
        rd_en <= 1'b1;
        rd_addr <= OFS_STATUS;
        repeat (3) @(posedge clk);
        ce <= 1'b1;
        rd_en <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge clk);
        if (q.size() > 0) n_errors++;
        give_verdict();
    end
endmodule : dpc_capture_unit_tb
